// >>> eqpo_defs.vh
// Functional notes
// - fixed boost used at 270M and 1.5G
// - fixed boost at 3G when adapt disabled
// - boost byte splits into four stage pairs
// - eye check per interval once locked, adapted
// - monitor enable bit 7, reset 0x80
// - adapt override follows mode field
// - no override: auto adapt when trace selected and fixed boost not used
// - route override picks strap or field
// - output override picks strap or field
// - rate override picks strap or field
// - boost override picks strap or manual settings
// - bit 0 enables 3G adapt, reset 0x01
// - four candidate boosts, documented reset values
// - routing field encodes four input routes
// - rate family 00 video, 01 ethernet
// - adapt mode 00 manual, 01 automatic
`ifndef EQPO_DEFS_VH
`define EQPO_DEFS_VH
`define EQPO_A_RSV_A 8'h39
`define EQPO_A_FIXED 8'h3a
`define EQPO_A_RSV_B 8'h3b
`define EQPO_A_RSV_C 8'h3c
`define EQPO_A_RSV_D 8'h3d
`define EQPO_A_MON 8'h3e
`define EQPO_A_OVR 8'h3f
`define EQPO_A_CAND0 8'h40
`define EQPO_A_CAND1 8'h41
`define EQPO_A_CAND2 8'h42
`define EQPO_A_CAND3 8'h43
`define EQPO_R_RSV_A 8'h00
`define EQPO_R_FIXED 8'h00
`define EQPO_R_RSV_B 8'h96
`define EQPO_R_RSV_C 8'h90
`define EQPO_R_RSV_D 8'h00
`define EQPO_R_MON 8'h80
`define EQPO_R_OVR 8'h01
`define EQPO_R_CAND0 8'h00
`define EQPO_R_CAND1 8'h40
`define EQPO_R_CAND2 8'h80
`define EQPO_R_CAND3 8'h50
`define EQPO_B_MON_EN 7
`define EQPO_B_ADAPT_OV 5
`define EQPO_B_ROUTE_OV 4
`define EQPO_B_OUT_OV 3
`define EQPO_B_RATE_OV 2
`define EQPO_B_BST_OV 1
`define EQPO_B_3G_EN 0
`define EQPO_RATE_270M 3'h0
`define EQPO_RATE_1G5 3'h1
`define EQPO_RATE_3G 3'h2
`define EQPO_ROUTE_TRACE_ONE 2'h2
`define EQPO_ROUTE_TRACE_BOTH 2'h3
`define EQPO_MODE_AUTO 2'h1
`define EQPO_IVL_UNIT 16
`endif

// >>> eqpo_sync.v
`timescale 1ns/1ps
module eqpo_sync #(
    parameter W = 4
) (
    input wire i_clk,
    input wire i_nrst,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    // first stage feeds only the second
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule

// >>> eqpo_regs.v
`timescale 1ns/1ps
`include "eqpo_defs.vh"
module eqpo_regs #(
    parameter IVL_W = 4,
    parameter IVL_UNIT = `EQPO_IVL_UNIT
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    output wire o_rd_hit,
    input wire [1:0] i_route_strap,
    input wire [1:0] i_outctl_strap,
    input wire [1:0] i_route_field,
    input wire [1:0] i_outmux_field,
    input wire [1:0] i_rate_field,
    input wire [1:0] i_adapt_mode_field,
    input wire i_manual_boost_apply,
    input wire [7:0] i_manual_boost,
    input wire [IVL_W-1:0] i_interval_sel,
    input wire [2:0] i_rate,
    input wire i_lock_done,
    input wire i_adapt_done,
    output reg [1:0] o_input_routing_field,
    output reg [1:0] o_outmux_sel,
    output reg [1:0] o_rate_family,
    output reg o_boost_bypass,
    output reg o_adapt_run,
    output reg o_use_fixed,
    output reg [7:0] o_boost,
    output reg [1:0] o_stage0,
    output reg [1:0] o_stage1,
    output reg [1:0] o_stage2,
    output reg [1:0] o_stage3,
    output reg o_eye_check,
    output wire [31:0] o_candidates
);
    reg [7:0] fixed_q;
    reg [7:0] rsv_d_q;
    reg [7:0] mon_q;
    reg [7:0] ovr_q;
    reg [7:0] cand_q [0:3];
    reg [15:0] ivl_cnt_q;
    wire [3:0] strap_s;
    wire [1:0] strap_route;
    wire [1:0] strap_out;
    wire trace_sel;
    wire low_rate;
    wire fixed_sel;
    wire [1:0] route_n;
    wire [15:0] ivl_len;
    wire [31:0] ivl_prod;
    // strap pins come from outside the clock domain
    eqpo_sync #(.W(4)) u_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_async({i_route_strap, i_outctl_strap}),
        .o_sync(strap_s)
    );
    assign strap_route = strap_s[3:2];
    assign strap_out = strap_s[1:0];

    function [1:0] stage_of;
        input [7:0] b;
        input [1:0] s;
        begin
            stage_of = b[7 - 2 * s -: 2];
        end
    endfunction

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            fixed_q <= `EQPO_R_FIXED;
            rsv_d_q <= `EQPO_R_RSV_D;
            mon_q <= `EQPO_R_MON;
            ovr_q <= `EQPO_R_OVR;
            cand_q[0] <= `EQPO_R_CAND0;
            cand_q[1] <= `EQPO_R_CAND1;
            cand_q[2] <= `EQPO_R_CAND2;
            cand_q[3] <= `EQPO_R_CAND3;
        end
        else if (i_wr_en)
        begin
            // read-only reserved offsets fall through untouched
            case (i_addr)
                `EQPO_A_FIXED: fixed_q <= i_wdata;
                `EQPO_A_RSV_D: rsv_d_q <= i_wdata;
                `EQPO_A_MON: mon_q <= i_wdata;
                `EQPO_A_OVR: ovr_q <= i_wdata;
                `EQPO_A_CAND0: cand_q[0] <= i_wdata;
                `EQPO_A_CAND1: cand_q[1] <= i_wdata;
                `EQPO_A_CAND2: cand_q[2] <= i_wdata;
                `EQPO_A_CAND3: cand_q[3] <= i_wdata;
                default:
                begin
                end
            endcase
        end
    end

    assign o_rd_hit = i_rd_en && (i_addr >= `EQPO_A_RSV_A) && (i_addr <= `EQPO_A_CAND3);
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_rdata <= 8'h00;
        else if (i_rd_en)
        begin
            case (i_addr)
                `EQPO_A_RSV_A: o_rdata <= `EQPO_R_RSV_A;
                `EQPO_A_FIXED: o_rdata <= fixed_q;
                `EQPO_A_RSV_B: o_rdata <= `EQPO_R_RSV_B;
                `EQPO_A_RSV_C: o_rdata <= `EQPO_R_RSV_C;
                `EQPO_A_RSV_D: o_rdata <= rsv_d_q;
                `EQPO_A_MON: o_rdata <= mon_q;
                `EQPO_A_OVR: o_rdata <= ovr_q;
                `EQPO_A_CAND0: o_rdata <= cand_q[0];
                `EQPO_A_CAND1: o_rdata <= cand_q[1];
                `EQPO_A_CAND2: o_rdata <= cand_q[2];
                `EQPO_A_CAND3: o_rdata <= cand_q[3];
                default: o_rdata <= 8'h00;
            endcase
        end
    end
    assign o_candidates = {cand_q[3], cand_q[2], cand_q[1], cand_q[0]};

    // routing and strap selection
    assign route_n = ovr_q[`EQPO_B_ROUTE_OV] ? i_route_field : strap_route;
    assign trace_sel = (route_n == `EQPO_ROUTE_TRACE_ONE) ||
                       (route_n == `EQPO_ROUTE_TRACE_BOTH);
    assign low_rate = (i_rate == `EQPO_RATE_270M) || (i_rate == `EQPO_RATE_1G5);
    assign fixed_sel = low_rate ||
        ((i_rate == `EQPO_RATE_3G) && !ovr_q[`EQPO_B_3G_EN]);

    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_input_routing_field <= 2'h0;
            o_outmux_sel <= 2'h0;
            o_rate_family <= 2'h0;
            o_boost_bypass <= 1'b0;
            o_adapt_run <= 1'b0;
            o_use_fixed <= 1'b0;
            o_boost <= 8'h00;
            o_stage0 <= 2'h0;
            o_stage1 <= 2'h0;
            o_stage2 <= 2'h0;
            o_stage3 <= 2'h0;
        end
        else
        begin
            o_input_routing_field <= route_n;
            o_outmux_sel <= ovr_q[`EQPO_B_OUT_OV] ? i_outmux_field : strap_out;
            // strap rate family: only trace-route codes imply ethernet
            o_rate_family <= ovr_q[`EQPO_B_RATE_OV] ? i_rate_field :
                             {1'b0, strap_route[1]};
            o_boost_bypass <= ovr_q[`EQPO_B_BST_OV] ? i_manual_boost_apply :
                              strap_out[0];
            if (ovr_q[`EQPO_B_ADAPT_OV])
                o_adapt_run <= trace_sel && !fixed_sel &&
                               (i_adapt_mode_field == `EQPO_MODE_AUTO);
            else
                o_adapt_run <= trace_sel && !fixed_sel;
            o_use_fixed <= trace_sel && fixed_sel;
            if (trace_sel && fixed_sel)
            begin
                o_boost <= fixed_q;
                o_stage0 <= stage_of(fixed_q, 2'd0);
                o_stage1 <= stage_of(fixed_q, 2'd1);
                o_stage2 <= stage_of(fixed_q, 2'd2);
                o_stage3 <= stage_of(fixed_q, 2'd3);
            end
            else if (ovr_q[`EQPO_B_BST_OV] && i_manual_boost_apply)
            begin
                o_boost <= i_manual_boost;
                o_stage0 <= stage_of(i_manual_boost, 2'd0);
                o_stage1 <= stage_of(i_manual_boost, 2'd1);
                o_stage2 <= stage_of(i_manual_boost, 2'd2);
                o_stage3 <= stage_of(i_manual_boost, 2'd3);
            end
        end
    end

    // eye-opening check interval; length scales with the select field
    // product kept wide, then cut: intervals beyond 16 bits wrap
    assign ivl_prod = ({{(32-IVL_W){1'b0}}, i_interval_sel} + 32'h00000001) * IVL_UNIT;
    assign ivl_len = ivl_prod[15:0];
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ivl_cnt_q <= 16'h0000;
            o_eye_check <= 1'b0;
        end
        else if (mon_q[`EQPO_B_MON_EN] && i_lock_done && i_adapt_done)
        begin
            o_eye_check <= (ivl_cnt_q + 16'h0001 >= ivl_len);
            ivl_cnt_q <= (ivl_cnt_q + 16'h0001 >= ivl_len) ? 16'h0000 :
                         ivl_cnt_q + 16'h0001;
        end
        else
        begin
            ivl_cnt_q <= 16'h0000;
            o_eye_check <= 1'b0;
        end
    end
endmodule

// >>> eqpo_regs_assertions.sv
`timescale 1ns/1ps
module eqpo_regs_chk (
    input wire i_clk,
    input wire i_nrst,
    input wire i_wr_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire [2:0] i_rate,
    input wire [1:0] i_route_field,
    input wire [1:0] i_outmux_field,
    input wire [1:0] i_rate_field,
    input wire [1:0] i_adapt_mode_field,
    input wire i_manual_boost_apply,
    input wire [7:0] o_boost,
    input wire [1:0] o_input_routing_field,
    input wire [1:0] o_outmux_sel,
    input wire [1:0] o_rate_family,
    input wire o_boost_bypass,
    input wire o_adapt_run,
    input wire o_use_fixed,
    input wire [1:0] o_stage0,
    input wire [1:0] o_stage1,
    input wire [1:0] o_stage2,
    input wire [1:0] o_stage3
);
    reg [7:0] ov_q;
    reg [7:0] fx_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // shadow of the two registers the outputs depend on
    always @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
        begin
            ov_q <= 8'h01;
            fx_q <= 8'h00;
        end
        else if (i_wr_en && i_addr == 8'h3f)
            ov_q <= i_wdata;
        else if (i_wr_en && i_addr == 8'h3a)
            fx_q <= i_wdata;
    sequence s_fixed_out;
        o_use_fixed && o_boost == $past(fx_q);
    endsequence
    // trace picked through the routing field override, strap path not visible here
    sequence s_trace_field;
        ov_q[4] && i_route_field[1];
    endsequence
    a_stage_split: assert property (
        o_boost == {o_stage0, o_stage1, o_stage2, o_stage3})
        else $error("stage split wrong");
    a_route_ovr: assert property (
        ov_q[4] |=> o_input_routing_field == $past(i_route_field))
        else $error("route override wrong");
    a_outmux_ovr: assert property (
        ov_q[3] |=> o_outmux_sel == $past(i_outmux_field))
        else $error("outmux override wrong");
    a_rate_ovr: assert property (
        ov_q[2] |=> o_rate_family == $past(i_rate_field))
        else $error("rate override wrong");
    a_boost_ovr: assert property (
        ov_q[1] |=> o_boost_bypass == $past(i_manual_boost_apply))
        else $error("bypass override wrong");
    a_fixed_low: assert property (
        s_trace_field ##0 i_rate < 3'h2 |=> s_fixed_out)
        else $error("fixed boost not used");
    a_fixed_3g: assert property (
        s_trace_field ##0 (i_rate == 3'h2 && !ov_q[0]) |=> s_fixed_out)
        else $error("fixed boost not used at 3g");
    a_adapt_held: assert property (
        ov_q[5] && i_adapt_mode_field == 2'h0 |=> !o_adapt_run)
        else $error("adapt not held");
    a_auto_adapt: assert property (
        s_trace_field ##0 (!ov_q[5] && i_rate > 3'h2) |=> o_adapt_run)
        else $error("auto adapt missing");
endmodule
bind eqpo_regs eqpo_regs_chk eqpo_regs_chk_i (.*);

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    reg i_clk, i_nrst, i_wr_en, i_rd_en, i_lock_done, i_adapt_done, i_manual_boost_apply;
    reg [7:0] i_addr, i_wdata, i_manual_boost;
    reg [1:0] i_route_strap, i_outctl_strap, i_route_field, i_outmux_field;
    reg [1:0] i_rate_field, i_adapt_mode_field;
    reg [3:0] i_interval_sel;
    reg [2:0] i_rate;
    wire [7:0] o_rdata, o_boost;
    wire o_rd_hit, o_boost_bypass, o_adapt_run, o_use_fixed, o_eye_check;
    wire [1:0] o_input_routing_field, o_outmux_sel, o_rate_family;
    wire [1:0] o_stage0, o_stage1, o_stage2, o_stage3;
    wire [31:0] o_candidates;
    int n_fail = 0, n_compared = 0, cyc = 0, a, e, f, k;
    int m[0:255];
    eqpo_regs eqpo_regs_i (.*);
    task test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input int ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            n_fail++;
            $display("BAD %s exp %0h got %0h", nm, ex, got);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask
    task wr(input int ad, input int d);
        settle(1);
        {i_wr_en, i_addr, i_wdata} = {1'b1, ad[7:0], d[7:0]};
        settle(1);
        i_wr_en = 0;
        // reserved read-only places keep their value
        if (ad == 'h3a || (ad >= 'h3d && ad <= 'h43)) m[ad] = d & 'hff;
    endtask
    task rd(input int ad);
        settle(1);
        {i_rd_en, i_addr} = {1'b1, ad[7:0]};
        settle(1);
        chk("rd_hit", ad >= 'h39 && ad <= 'h43, o_rd_hit);
        i_rd_en = 0;
        chk("rdata", m[ad], o_rdata);
    endtask
    initial
    begin
        i_clk = 0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
        if (++cyc == 5000)
        begin
            n_fail++;
            test_done();
        end
    initial
    begin
        {i_nrst, i_wr_en, i_rd_en, i_lock_done, i_adapt_done, i_manual_boost_apply} = 0;
        {i_addr, i_wdata, i_manual_boost, i_route_strap, i_outctl_strap} = 0;
        {i_route_field, i_outmux_field, i_rate_field, i_adapt_mode_field} = 0;
        {i_interval_sel, i_rate} = 0;
        for (a = 0; a < 256; a++)
            m[a] = 0;
        m['h3b] = 'h96;
        m['h3c] = 'h90;
        m['h3e] = 'h80;
        m['h3f] = 'h01;
        m['h41] = 'h40;
        m['h42] = 'h80;
        m['h43] = 'h50;
        k = $urandom(33941);
        settle(6);
        i_nrst = 1;
        for (a = 'h38; a <= 'h44; a++) rd(a);
        for (a = 'h38; a <= 'h44; a++) wr(a, $urandom);
        for (a = 'h38; a <= 'h44; a++) rd(a);
        e = m['h43] << 24 | m['h42] << 16 | m['h41] << 8 | m['h40];
        chk("cand", e, o_candidates);
        for (k = 0; k < 16; k++)
        begin
            wr('h3f, {k[0], 4'hf, k[1]});
            {i_route_field, i_outmux_field, i_rate_field, i_adapt_mode_field} = $urandom;
            {i_manual_boost_apply, i_manual_boost, i_rate} = $urandom;
            settle(2);
            // fixed boost only reaches the trace equalizer when trace is routed
            f = i_rate < 2 || (i_rate == 2 && !k[1]);
            e = f && i_route_field[1];
            chk("route", i_route_field, o_input_routing_field);
            chk("outmux", i_outmux_field, o_outmux_sel);
            chk("rate", i_rate_field, o_rate_family);
            chk("bypass", i_manual_boost_apply, o_boost_bypass);
            chk("fixed", e, o_use_fixed);
            a = !f && i_route_field[1] && (!k[0] || i_adapt_mode_field == 1);
            chk("adapt", a, o_adapt_run);
            if (e)
            begin
                chk("stages", m['h3a], {o_stage0, o_stage1, o_stage2, o_stage3});
                chk("boost", m['h3a], o_boost);
            end
            else if (i_manual_boost_apply)
                chk("manual", i_manual_boost, o_boost);
        end
        wr('h3f, 0);
        {i_route_strap, i_outctl_strap} = $urandom;
        settle(4);
        chk("s_route", i_route_strap, o_input_routing_field);
        chk("s_out", i_outctl_strap, o_outmux_sel);
        chk("s_rate", i_route_strap[1], o_rate_family);
        chk("s_byp", i_outctl_strap[0], o_boost_bypass);
        for (e = 0; e < 2; e++)
        begin
            // interval 16 cycles: six pulses fit in 100, none when disabled
            wr('h3e, e ? 'h7f : 'h80);
            {i_lock_done, i_adapt_done} = 2'h3;
            a = 0;
            repeat (100)
            begin
                settle(1);
                a += o_eye_check;
            end
            chk("eye", e ? 0 : 6, a);
        end
        test_done();
    end
endmodule
